//--- design/tfa_pkg.sv
package tfa_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] TSC_OFF = 8'h00;
  localparam logic [7:0] OVF_OFF = 8'h04;
  localparam logic [7:0] CNT_OFF = 8'h08;
  localparam logic [7:0] FSEL_OFF = 8'h0C;
  localparam logic [7:0] EDGE_OFF = 8'h10;
  localparam logic [7:0] PULSE_ACCUM_CONTROL_OFF = 8'h20;
  localparam logic [7:0] PAFLG_OFF = 8'h24;
  localparam logic [7:0] PACNT_OFF = 8'h28;
  localparam logic [7:0] CHAN_BASE = 8'h40;
  localparam logic [7:0] CHAN_LAST = 8'h5C;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int TSC_EN_BIT = 7;
  localparam int TSC_FFC_BIT = 4;
  localparam int OVF_FLAG_BIT = 7;
  localparam int PAF_OVF_BIT = 1;
  localparam int PAF_IN_BIT = 0;
  localparam int SHARED_PIN = 7;
  localparam int NUM_CHAN = 8;
  // Channel 6 is left out to give the reserved-register behaviour
  localparam logic [7:0] CHAN_PRESENT = 8'hBF;
  // ---------------------------------------------------------------
  // Reset values and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] REG8_RST = 8'h00;
  localparam logic [15:0] REG16_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [7:0] LOW_MAX = 8'hFF;
  localparam int DIV_SLOW = 64;
  localparam logic [5:0] DIV_LAST = 6'(DIV_SLOW - 1);
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CLK_PRESCALE, CLK_ACCUM, CLK_ACCUM_256, CLK_ACCUM_64K
  } tfa_clk_sel_type;

  typedef struct packed {
    logic rsvd;
    logic accum_enable;
    logic accum_mode_select;
    logic accum_edge_select;
    tfa_clk_sel_type clk_sel;
    logic accum_overflow_irq_enable;
    logic accum_input_irq_enable;
  } tfa_pulse_accum_control_type;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } tfa_wb_req_type;
endpackage

//--- design/tfa_timer.sv
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
// Summary of operation
// - Counter overflow flag sets when free-running counter wraps FFFF to 0000.
// - Writing one to flag bit 7 clears it, only while timer or accum enabled.
// - With fast clear on, any counter access clears the overflow flags, only while timer or accum enabled.
// - Capture channels latch the counter on the configured pin transition.
// - Compare channels hold the value that triggers the channel action.
// - Channel register writes work in compare mode, ignored in capture mode.
// - All channel capture/compare registers reset to zero.
// - Absent channel registers read zero and ignore writes.
// - Accumulator enable works independently of the timer enable, except gated counting needs the timer's div-64 tick.
// - The accumulator input is the channel seven pin.
// - Mode bit picks event count or gated time, only while enabled.
// - Event mode counts falling edges, or rising when edge select set.
// - Gated, edge select zero: high level gates div-64 tick; fall flags.
// - Gated, edge select one: low level gates div-64 tick; rise flags.
// - Overflow interrupt requested while its flag and enable are set.
// - Input interrupt requested while its flag and enable are set.
// - Clock select: prescaler, accum clock, accum/256, accum/65536.
// - Accumulator disabled forces prescaler clock; selection acts at once.
// - Accumulator overflow flag sets when count wraps FFFF to 0000.
module tfa_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire tfa_pkg::tfa_wb_req_type wb_req_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] chan_pin_i,
  output logic [7:0] chan_event_o,
  output logic accum_overflow_irq_o,
  output logic accum_input_irq_o
);
  import tfa_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic timer_global_enable;
  logic fast_flag_clear;
  logic counter_overflow_flag;
  logic [15:0] free_running_counter;
  logic [7:0] channel_function_select;
  logic [15:0] capture_edge_cfg;
  tfa_pulse_accum_control_type pulse_accum_control;
  logic accum_overflow_flag;
  logic accum_input_flag;
  logic [15:0] accum_count;
  logic [15:0] chan_value [NUM_CHAN];
  logic [7:0] high_hold;
  logic [7:0] pin_prev;
  logic [5:0] slow_div;
  logic [31:0] next_dat;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic bus_req;
  logic bus_done;
  logic wr;
  logic rd;
  logic wr_lo;
  logic wr_hi;
  logic chan_hit;
  logic [2:0] chan_idx;
  logic [7:0] adr;
  logic [31:0] wdat;

  assign adr = wb_req_i.adr;
  assign wdat = wb_req_i.dat;
  assign bus_req = wb_req_i.cyc && wb_req_i.stb;
  // Action happens on the edge where the master samples ack
  assign bus_done = bus_req && wb_ack_o;
  assign wr = bus_done && wb_req_i.we;
  assign rd = bus_done && !wb_req_i.we;
  assign wr_lo = wr && wb_req_i.sel[0];
  assign wr_hi = wr && wb_req_i.sel[1];
  assign chan_hit = (adr >= CHAN_BASE) && (adr <= CHAN_LAST)
                    && (adr[1:0] == 2'b00);
  assign chan_idx = adr[4:2];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
    end
  end

  // ---------------------------------------------------------------
  // Pin sampling and slow tick
  // ---------------------------------------------------------------
  logic channel_seven_pin;
  logic pa_rise;
  logic pa_fall;
  logic slow_tick;
  logic [7:0] rise;
  logic [7:0] fall;

  assign channel_seven_pin = chan_pin_i[SHARED_PIN];
  assign rise = chan_pin_i & ~pin_prev;
  assign fall = ~chan_pin_i & pin_prev;
  assign pa_rise = rise[SHARED_PIN];
  assign pa_fall = fall[SHARED_PIN];
  // Divide-by-64 comes from the timer prescaler, so no tick without it
  assign slow_tick = timer_global_enable && (slow_div == DIV_LAST);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_prev <= REG8_RST;
    end else begin
      pin_prev <= chan_pin_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slow_div <= '0;
    end else if (!timer_global_enable) begin
      slow_div <= '0;
    end else begin
      slow_div <= slow_div + 6'h01;
    end
  end

  // ---------------------------------------------------------------
  // Pulse accumulator
  // ---------------------------------------------------------------
  logic pa_on;
  logic pa_gated;
  logic pa_inc;
  logic pa_flag_edge;
  logic pa_wrap;
  logic pa_access;
  logic flag_clear_ok;

  assign pa_on = pulse_accum_control.accum_enable;
  assign pa_gated = pulse_accum_control.accum_mode_select;
  // Same edge ends a gate and counts an event
  assign pa_flag_edge = pulse_accum_control.accum_edge_select ?
                        pa_rise : pa_fall;
  assign pa_inc = pa_on && (pa_gated ?
    (slow_tick && (channel_seven_pin
                   != pulse_accum_control.accum_edge_select)) :
    pa_flag_edge);
  assign pa_wrap = pa_inc && (accum_count == CNT_MAX);
  assign pa_access = bus_done && (adr == PACNT_OFF);
  assign flag_clear_ok = timer_global_enable || pa_on;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      accum_count <= REG16_RST;
    end else begin
      if (pa_inc) begin
        accum_count <= accum_count + 16'h0001;
      end
      if (wr && adr == PACNT_OFF) begin
        if (wb_req_i.sel[1]) begin
          accum_count[15:8] <= wdat[15:8];
        end
        if (wb_req_i.sel[0]) begin
          accum_count[7:0] <= wdat[7:0];
        end
      end
    end
  end

  // Set wins over any clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      accum_overflow_flag <= 1'b0;
      accum_input_flag <= 1'b0;
    end else begin
      if (flag_clear_ok && fast_flag_clear && pa_access) begin
        accum_overflow_flag <= 1'b0;
        accum_input_flag <= 1'b0;
      end
      if (flag_clear_ok && wr_lo && adr == PAFLG_OFF) begin
        if (wdat[PAF_OVF_BIT]) begin
          accum_overflow_flag <= 1'b0;
        end
        if (wdat[PAF_IN_BIT]) begin
          accum_input_flag <= 1'b0;
        end
      end
      if (pa_wrap) begin
        accum_overflow_flag <= 1'b1;
      end
      if (pa_on && pa_flag_edge) begin
        accum_input_flag <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      accum_overflow_irq_o <= 1'b0;
      accum_input_irq_o <= 1'b0;
    end else begin
      accum_overflow_irq_o <= accum_overflow_flag
        && pulse_accum_control.accum_overflow_irq_enable;
      accum_input_irq_o <= accum_input_flag
        && pulse_accum_control.accum_input_irq_enable;
    end
  end

  // ---------------------------------------------------------------
  // Free-running counter
  // ---------------------------------------------------------------
  logic cnt_tick;
  logic cnt_wrap;
  logic cnt_access;

  always_comb begin
    cnt_tick = 1'b0;
    if (!pa_on) begin
      cnt_tick = timer_global_enable;
    end else begin
      unique case (pulse_accum_control.clk_sel)
        CLK_PRESCALE: cnt_tick = timer_global_enable;
        CLK_ACCUM: cnt_tick = timer_global_enable && pa_inc;
        CLK_ACCUM_256: cnt_tick = timer_global_enable && pa_inc
                                  && (accum_count[7:0] == LOW_MAX);
        CLK_ACCUM_64K: cnt_tick = timer_global_enable && pa_wrap;
      endcase
    end
  end

  assign cnt_wrap = cnt_tick && (free_running_counter == CNT_MAX);
  assign cnt_access = bus_done && (adr == CNT_OFF);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      free_running_counter <= REG16_RST;
    end else if (cnt_tick) begin
      free_running_counter <= free_running_counter + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter_overflow_flag <= 1'b0;
    end else begin
      if (flag_clear_ok && fast_flag_clear && cnt_access) begin
        counter_overflow_flag <= 1'b0;
      end
      if (flag_clear_ok && wr_lo && adr == OVF_OFF
          && wdat[OVF_FLAG_BIT]) begin
        counter_overflow_flag <= 1'b0;
      end
      if (cnt_wrap) begin
        counter_overflow_flag <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_global_enable <= 1'b0;
      fast_flag_clear <= 1'b0;
      channel_function_select <= REG8_RST;
      capture_edge_cfg <= REG16_RST;
      pulse_accum_control <= tfa_pulse_accum_control_type'(REG8_RST);
    end else begin
      if (wr_lo && adr == TSC_OFF) begin
        timer_global_enable <= wdat[TSC_EN_BIT];
        fast_flag_clear <= wdat[TSC_FFC_BIT];
      end
      if (wr_lo && adr == FSEL_OFF) begin
        channel_function_select <= wdat[7:0] & CHAN_PRESENT;
      end
      if (wr_lo && adr == EDGE_OFF) begin
        capture_edge_cfg[7:0] <= wdat[7:0];
      end
      if (wr_hi && adr == EDGE_OFF) begin
        capture_edge_cfg[15:8] <= wdat[15:8];
      end
      if (wr_lo && adr == PULSE_ACCUM_CONTROL_OFF) begin
        pulse_accum_control <= tfa_pulse_accum_control_type'({1'b0, wdat[6:0]});
      end
    end
  end

  // ---------------------------------------------------------------
  // Capture / compare channels
  // ---------------------------------------------------------------
  logic [7:0] cap_hit;
  logic [7:0] cmp_hit;

  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      cap_hit[i] = CHAN_PRESENT[i] && !channel_function_select[i]
        && ((capture_edge_cfg[2*i] && rise[i])
            || (capture_edge_cfg[2*i+1] && fall[i]));
      cmp_hit[i] = CHAN_PRESENT[i] && channel_function_select[i]
        && cnt_tick && (free_running_counter == chan_value[i]);
    end
  end

  // Lone high-byte write is held until the low byte completes it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_hold <= REG8_RST;
    end else if (wr_hi && chan_hit) begin
      high_hold <= wdat[15:8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        chan_value[i] <= REG16_RST;
      end
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        if (cap_hit[i]) begin
          chan_value[i] <= free_running_counter;
        end else if (wr_lo && chan_hit && chan_idx == 3'(i)
                     && CHAN_PRESENT[i]
                     && channel_function_select[i]) begin
          chan_value[i] <= {wb_req_i.sel[1] ? wdat[15:8] : high_hold,
                            wdat[7:0]};
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_event_o <= REG8_RST;
    end else begin
      chan_event_o <= cap_hit | cmp_hit;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  always_comb begin
    next_dat = '0;
    if (chan_hit) begin
      if (CHAN_PRESENT[chan_idx]) begin
        next_dat[15:0] = chan_value[chan_idx];
      end
    end else begin
      unique case (adr)
        TSC_OFF: begin
          next_dat[TSC_EN_BIT] = timer_global_enable;
          next_dat[TSC_FFC_BIT] = fast_flag_clear;
        end
        OVF_OFF: next_dat[OVF_FLAG_BIT] = counter_overflow_flag;
        CNT_OFF: next_dat[15:0] = free_running_counter;
        FSEL_OFF: next_dat[7:0] = channel_function_select;
        EDGE_OFF: next_dat[15:0] = capture_edge_cfg;
        PULSE_ACCUM_CONTROL_OFF: next_dat[7:0] = pulse_accum_control;
        PAFLG_OFF: begin
          next_dat[PAF_OVF_BIT] = accum_overflow_flag;
          next_dat[PAF_IN_BIT] = accum_input_flag;
        end
        PACNT_OFF: next_dat[15:0] = accum_count;
        default: next_dat = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (bus_req && !wb_ack_o && !wb_req_i.we) begin
      wb_dat_o <= next_dat;
    end else begin
      wb_dat_o <= '0;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ovf_set_wrap: assert property (
    cnt_wrap |=> counter_overflow_flag)
    else $error("overflow flag not set on counter wrap");
  a_ovf_clear_gate: assert property (
    (counter_overflow_flag && !flag_clear_ok && !cnt_wrap)
      |=> counter_overflow_flag)
    else $error("overflow flag cleared while timer idle");
  a_ovf_w1c_clear: assert property (
    (flag_clear_ok && wr_lo && adr == OVF_OFF && wdat[OVF_FLAG_BIT]
     && !cnt_wrap) |=> !counter_overflow_flag)
    else $error("overflow flag not cleared by write of one");
  a_fast_clear_cnt: assert property (
    (fast_flag_clear && cnt_access && flag_clear_ok && !cnt_wrap)
      |=> !counter_overflow_flag)
    else $error("fast clear missed on counter access");
  a_capture_value: assert property (
    cap_hit[0] |=> chan_value[0] == $past(free_running_counter))
    else $error("channel zero capture value wrong");
  a_capture_wr_ignored: assert property (
    (wr_lo && chan_hit && chan_idx == 3'd1
     && !channel_function_select[1] && !cap_hit[1])
      |=> $stable(chan_value[1]))
    else $error("write took effect in capture mode");
  a_absent_reads_zero: assert property (
    (rd && chan_hit && !CHAN_PRESENT[chan_idx]) |-> wb_dat_o == '0)
    else $error("absent channel read not zero");
  a_accum_wrap_flag: assert property (
    pa_wrap |=> accum_overflow_flag && accum_count == 16'h0000)
    else $error("accumulator wrap not flagged");
  a_accum_disabled_idle: assert property (
    (!pa_on && !(wr && adr == PACNT_OFF)) |=> $stable(accum_count))
    else $error("accumulator moved while disabled");
  a_gated_count: assert property (
    (pa_on && pa_gated && !pulse_accum_control.accum_edge_select
     && slow_tick && channel_seven_pin
     && !(wr && adr == PACNT_OFF))
      |=> accum_count == $past(accum_count) + 16'h0001)
    else $error("gated accumulation missed a tick");
  a_event_edge_count: assert property (
    (pa_on && !pa_gated && !pulse_accum_control.accum_edge_select
     && pa_fall && !(wr && adr == PACNT_OFF))
      |=> accum_count == $past(accum_count) + 16'h0001)
    else $error("falling edge not counted with falling select");
  a_prescale_forced: assert property (
    !pa_on |-> cnt_tick == timer_global_enable)
    else $error("counter clock not prescaler while accum off");
  a_irq_follow: assert property (
    ##1 (accum_overflow_irq_o == $past(accum_overflow_flag
      && pulse_accum_control.accum_overflow_irq_enable))
    && (accum_input_irq_o == $past(accum_input_flag
      && pulse_accum_control.accum_input_irq_enable)))
    else $error("interrupt request does not follow flag");
  a_bus_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  c_counter_wrap: cover property (cnt_wrap);
  c_capture_event: cover property (|cap_hit);
  c_gated_trailing: cover property (pa_on && pa_gated && pa_flag_edge);
  c_accum_clocked_counter: cover property (pa_on && cnt_tick
    && pulse_accum_control.clk_sel == CLK_ACCUM);
endmodule // tfa_timer

//--- tb/test_tfa_timer.sv
`timescale 1ns/1ps
module test_tfa_timer;
  import tfa_pkg::*;
  typedef struct {
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wd;
    logic [31:0] exp;
  } tfa_row_type;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  tfa_wb_req_type req = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [6:0] pins = 7'h00;
  logic pin7;
  logic busy;
  logic go = 1'b0;
  logic [15:0] hi = 16'h0000;
  logic ovf_irq;
  logic in_irq;
  logic [31:0] v;
  logic [31:0] c1;
  logic [31:0] c2;
  logic [7:0] evt;
  logic [7:0] evt_seen;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc_cnt = 0;
  tfa_row_type rows [8] = '{
    '{FSEL_OFF, 4'h1, 32'hFF, 32'hBF},
    '{CHAN_BASE, 4'h3, 32'h1234, 32'h1234},
    '{8'h58, 4'h3, 32'hBEEF, 32'h0},
    '{CHAN_LAST, 4'h3, 32'hFFFF, 32'hFFFF},
    '{OVF_OFF, 4'h1, 32'h7F, 32'h0},
    '{CNT_OFF, 4'h3, 32'h1234, 32'h0},
    '{8'h30, 4'hF, 32'hFFFFFFFF, 32'h0},
    '{PULSE_ACCUM_CONTROL_OFF, 4'h1, 32'hFF, 32'h7F}
  };

  always #2.5 clk_i = ~clk_i;

  tfa_timer DUT (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_req_i(req),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .chan_pin_i({pin7, pins}),
    .chan_event_o(evt),
    .accum_overflow_irq_o(ovf_irq),
    .accum_input_irq_o(in_irq)
  );

  tfa_pin_model partner (
    .clk_i(clk_i),
    .go_i(go),
    .hi_len_i(hi),
    .pin_o(pin7),
    .busy_o(busy)
  );

  // ---------------------------------------------------------------
  // Checking and bus tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic we, input logic [7:0] adr,
      input logic [3:0] sel, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (wb_ack_o !== 1'b1) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, wb_ack_o, 1'b1);
    end
    rd = wb_dat_o;
    req <= '0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [3:0] sel,
      input logic [31:0] wd);
    logic [31:0] dummy;
    bus(1'b1, adr, sel, wd, dummy);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] got;
    bus(1'b0, adr, 4'hF, 32'h0, got);
    chk_val(got, exp);
  endtask

  task automatic pulse(input logic [15:0] len, input int cnt);
    repeat (cnt) begin
      @(posedge clk_i);
      go <= 1'b1;
      hi <= len;
      @(posedge clk_i);
      go <= 1'b0;
      @(posedge clk_i);
      while (busy) @(posedge clk_i);
    end
  endtask

  // Sticky record of channel event pulses, cleared by reset
  always @(posedge clk_i) begin
    if (rst_i) begin
      evt_seen <= 8'h00;
    end else begin
      evt_seen <= evt_seen | evt;
    end
  end

  // Hang guard: overflow wait dominates the run
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 90000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].adr, rows[i].sel, rows[i].wd);
      rd_chk(rows[i].adr, rows[i].exp);
    end
    // Second reset in mid-run brings every register back
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(PULSE_ACCUM_CONTROL_OFF, 32'h0);
    rd_chk(CHAN_BASE, 32'h0);
    rd_chk(CHAN_LAST, 32'h0);
    rd_chk(FSEL_OFF, 32'h0);
    // Split byte write, high byte first
    wr(FSEL_OFF, 4'h1, 32'hBF);
    wr(8'h44, 4'h2, 32'hAB00);
    wr(8'h44, 4'h1, 32'hCD);
    rd_chk(8'h44, 32'hABCD);
    wr(FSEL_OFF, 4'h1, 32'h0);
    wr(8'h44, 4'h3, 32'h5555);
    rd_chk(8'h44, 32'hABCD);
    // Capture on channel two rising edge, counter running
    wr(EDGE_OFF, 4'h1, 32'h10);
    wr(TSC_OFF, 4'h1, 32'h80);
    bus(1'b0, CNT_OFF, 4'hF, 32'h0, c1);
    pins[2] <= 1'b1;
    bus(1'b0, 8'h48, 4'hF, 32'h0, v);
    bus(1'b0, CNT_OFF, 4'hF, 32'h0, c2);
    chk_bit(v[15:0] > c1[15:0] && v[15:0] < c2[15:0], 1'b1);
    chk_val({24'h0, evt_seen}, 32'h4);
    // Event counting on both edge choices, timer off
    wr(TSC_OFF, 4'h1, 32'h0);
    for (int e = 0; e < 2; e++) begin
      wr(PULSE_ACCUM_CONTROL_OFF, 4'h1, 32'h41 | (32'(e) << 4));
      wr(PAFLG_OFF, 4'h1, 32'h3);
      wr(PACNT_OFF, 4'h3, 32'h0);
      pulse(16'h0002, 3);
      rd_chk(PACNT_OFF, 32'h3);
      rd_chk(PAFLG_OFF, 32'h1);
      chk_bit(in_irq, 1'b1);
    end
    // Accumulator wrap
    wr(PULSE_ACCUM_CONTROL_OFF, 4'h1, 32'h53);
    wr(PACNT_OFF, 4'h3, 32'hFFFF);
    wr(PAFLG_OFF, 4'h1, 32'h3);
    pulse(16'h0002, 1);
    rd_chk(PACNT_OFF, 32'h0);
    rd_chk(PAFLG_OFF, 32'h3);
    chk_bit(ovf_irq, 1'b1);
    wr(PULSE_ACCUM_CONTROL_OFF, 4'h1, 32'h50);
    // Request register lags the enable by one edge
    repeat (2) @(posedge clk_i);
    chk_bit(ovf_irq, 1'b0);
    chk_bit(in_irq, 1'b0);
    // Gated by high level: 640 cycles give about ten ticks of 64
    wr(TSC_OFF, 4'h1, 32'h80);
    wr(PULSE_ACCUM_CONTROL_OFF, 4'h1, 32'h60);
    wr(PAFLG_OFF, 4'h1, 32'h3);
    wr(PACNT_OFF, 4'h3, 32'h0);
    pulse(16'd639, 1);
    bus(1'b0, PACNT_OFF, 4'hF, 32'h0, v);
    chk_bit(v >= 32'h9 && v <= 32'hB, 1'b1);
    rd_chk(PAFLG_OFF, 32'h1);
    // Gated by low level: rise ends the gate
    wr(PULSE_ACCUM_CONTROL_OFF, 4'h1, 32'h70);
    wr(PAFLG_OFF, 4'h1, 32'h3);
    pulse(16'h0003, 1);
    rd_chk(PAFLG_OFF, 32'h1);
    // Counter clocked by accumulator falling edges
    wr(PULSE_ACCUM_CONTROL_OFF, 4'h1, 32'h44);
    bus(1'b0, CNT_OFF, 4'hF, 32'h0, c1);
    pulse(16'h0002, 3);
    bus(1'b0, CNT_OFF, 4'hF, 32'h0, c2);
    chk_val(c2 - c1, 32'h3);
    // Free-running counter wrap, clear refusals and fast clear
    wr(PULSE_ACCUM_CONTROL_OFF, 4'h1, 32'h0);
    v = 32'h0;
    for (int n = 0; n < 30000 && v !== 32'h80; n++) begin
      bus(1'b0, OVF_OFF, 4'hF, 32'h0, v);
    end
    chk_val(v, 32'h80);
    wr(TSC_OFF, 4'h1, 32'h0);
    wr(OVF_OFF, 4'h1, 32'h80);
    rd_chk(OVF_OFF, 32'h80);
    wr(TSC_OFF, 4'h1, 32'h90);
    bus(1'b0, CNT_OFF, 4'hF, 32'h0, v);
    rd_chk(OVF_OFF, 32'h0);
    wr(OVF_OFF, 4'h1, 32'h80);
    give_verdict();
  end
endmodule // test_tfa_timer

//--- tb/tfa_pin_model.sv
`timescale 1ns/1ps
module tfa_pin_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [15:0] hi_len_i,
  output logic pin_o,
  output logic busy_o
);
  logic [15:0] left;

  initial begin
    pin_o = 1'b0;
    busy_o = 1'b0;
    left = 16'h0000;
  end

  // ---------------------------------------------------------------
  // Pulse source on the shared channel seven pin
  // ---------------------------------------------------------------
  // Low gap after each pulse so the next rise is a distinct edge
  always @(posedge clk_i) begin
    if (!busy_o && go_i) begin
      busy_o <= 1'b1;
      pin_o <= 1'b1;
      left <= hi_len_i;
    end else if (busy_o) begin
      if (left != 16'h0000) begin
        left <= left - 16'h0001;
      end else if (pin_o) begin
        pin_o <= 1'b0;
        left <= 16'h0003;
      end else begin
        busy_o <= 1'b0;
      end
    end
  end
endmodule // tfa_pin_model
